// ===== pkg/pifeb_pkg.sv
package pifeb_pkg;

	localparam int unsigned PIFEB_ADDR_W = 8;
	localparam int unsigned PIFEB_DATA_W = 32;
	localparam int unsigned PIFEB_REG_W = 8;

	// Byte addresses of the word-aligned registers
	localparam logic [7:0] OFS_FLAGS3 = 8'h00;
	localparam logic [7:0] OFS_ENABLE1 = 8'h04;
	localparam logic [7:0] OFS_ENABLE2 = 8'h08;
	localparam logic [7:0] OFS_ENABLE3 = 8'h0C;

	// Bit positions in the third flag and third enable register
	localparam int unsigned BIT_SP2_DONE = 7;
	localparam int unsigned BIT_SP2_COLL = 6;
	localparam int unsigned BIT_UART2_RX = 5;
	localparam int unsigned BIT_UART2_TX = 4;
	localparam int unsigned BIT_TMR4 = 3;
	localparam int unsigned BIT_CC5 = 2;
	localparam int unsigned BIT_CC4 = 1;
	localparam int unsigned BIT_CC3 = 0;

	// Bit positions in the second enable register
	localparam int unsigned BIT_OSC_FAIL = 7;
	localparam int unsigned BIT_COMPARATOR = 6;
	localparam int unsigned BIT_NETWORK = 5;
	localparam int unsigned BIT_RESERVED2 = 4;
	localparam int unsigned BIT_SP1_COLL = 3;
	localparam int unsigned BIT_UNIMPL2 = 2;
	localparam int unsigned BIT_TMR3_OVF = 1;
	localparam int unsigned BIT_CC2 = 0;

	// Implemented-bit masks
	localparam logic [7:0] MASK_EN1_BASE = 8'h7F;
	localparam logic [7:0] MASK_EN1_PARPORT = 8'h80;
	localparam logic [7:0] MASK_EN2_IMPL = 8'hFB;
	localparam logic [7:0] MASK_EN2_REQ = 8'hEB;
	localparam logic [7:0] MASK_FL2_REQ = 8'hEB;
	localparam logic [7:0] MASK_SET3_BASE = 8'h0F;
	localparam logic [7:0] MASK_SET3_MID = 8'h30;
	localparam logic [7:0] MASK_SET3_MAX = 8'hC0;
	localparam logic [7:0] MASK_FL3_RO = 8'h30;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;

	localparam int unsigned PINS_MID = 80;
	localparam int unsigned PINS_MAX = 100;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0]
	{
		WS_IDLE = 3'b000,
		WS_GOT_ADDR = 3'b001,
		WS_GOT_DATA = 3'b010,
		WS_COMMIT = 3'b011,
		WS_RESP = 3'b100
	} pifeb_wstate_t;

	typedef enum logic [2:0]
	{
		SEL_NONE = 3'b000,
		SEL_FLAGS3 = 3'b001,
		SEL_ENABLE1 = 3'b010,
		SEL_ENABLE2 = 3'b011,
		SEL_ENABLE3 = 3'b100
	} pifeb_sel_t;

endpackage : pifeb_pkg

// ===== verilog/pifeb_sticky_flag.sv
`timescale 1ns/10ps
`default_nettype none

module pifeb_sticky_flag
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic set_evt,
	input wire logic wr_en,
	input wire logic wr_val,
	output var logic flag_q
);

	logic flag_reg;
	logic flag_next;

	// Event beats a software clear in the same cycle
	always_comb
	begin
		flag_next = flag_reg;
		if (wr_en)
		begin
			flag_next = wr_val;
		end
		if (set_evt)
		begin
			flag_next = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			flag_reg <= 1'b0;
		end
		else
		begin
			flag_reg <= flag_next;
		end
	end

	assign flag_q = flag_reg;

endmodule : pifeb_sticky_flag

`default_nettype wire

// ===== verilog/pifeb_bank.sv
// How it works
// - Port-2 serial done flag sticky until written
// - Port-2 collision flag sticky until written
// - Receive flag read-only, follows buffer full level
// - Transmit flag read-only, follows buffer empty level
// - Timer-4 match flag sticky until written
// - Unit-5 flag on capture/compare, not PWM
// - Unit-4 flag on capture/compare, not PWM
// - Unit-3 flag on capture/compare, not PWM
// - Per-source enable bit: one enables, zero disables
// - No priorities: request needs peripheral enable
// - Unimplemented bits ignore writes, read zero
// - Enable-2 layout: osc, comp, network, coll, timer, capture
// - Enable-1 layout; parallel port only largest, microcontroller
// - Upper third-register bits depend on package size
// - Third enable register mirrors third flag register
// - All flag and enable bits reset zero
// - Flags latch regardless of enables
// - Priority control picks two-level or single-level
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module pifeb_bank
	import pifeb_pkg::*;
#(
	parameter int unsigned PIN_COUNT = 100
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output var logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output var logic s_axi_wready,
	output var logic [1:0] s_axi_bresp,
	output var logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output var logic s_axi_arready,
	output var logic [31:0] s_axi_rdata,
	output var logic [1:0] s_axi_rresp,
	output var logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_port2_done_evt,
	input wire logic serial_port2_collision_evt,
	input wire logic uart2_rx_full,
	input wire logic uart2_tx_empty,
	input wire logic timer_four_match_evt,
	input wire logic capcomp_five_evt,
	input wire logic capcomp_four_evt,
	input wire logic capcomp_three_evt,
	input wire logic [2:0] capcomp_pwm_mode,
	input wire logic microcontroller_mode,
	input wire logic [7:0] periph_irq_flags_1,
	input wire logic [7:0] periph_irq_flags_2,
	input wire logic peripheral_irq_enable,
	input wire logic priority_levels_enable,
	output var logic [7:0] periph_irq_flags_3_q,
	output var logic [7:0] periph_irq_enable_1_q,
	output var logic [7:0] periph_irq_enable_2_q,
	output var logic [7:0] periph_irq_enable_3_q,
	output var logic periph_irq_req
);

	localparam logic [7:0] IMPL3 = MASK_SET3_BASE
		| ((PIN_COUNT >= PINS_MID) ? MASK_SET3_MID : RESET_BYTE)
		| ((PIN_COUNT >= PINS_MAX) ? MASK_SET3_MAX : RESET_BYTE);
	localparam logic [7:0] IMPL3_SW = IMPL3 & ~MASK_FL3_RO;

	function automatic pifeb_sel_t decode_addr(input logic [7:0] addr);
		pifeb_sel_t sel;
		begin
			case (addr)
				OFS_FLAGS3: sel = SEL_FLAGS3;
				OFS_ENABLE1: sel = SEL_ENABLE1;
				OFS_ENABLE2: sel = SEL_ENABLE2;
				OFS_ENABLE3: sel = SEL_ENABLE3;
				default: sel = SEL_NONE;
			endcase
			decode_addr = sel;
		end
	endfunction : decode_addr

	// Parallel port enable exists only on the largest package in microcontroller mode
	logic [7:0] impl1;
	always_comb
	begin
		impl1 = MASK_EN1_BASE;
		if ((PIN_COUNT >= PINS_MAX) && microcontroller_mode)
		begin
			impl1 = MASK_EN1_BASE | MASK_EN1_PARPORT;
		end
	end

	// Write channel
	pifeb_wstate_t wstate_reg;
	pifeb_wstate_t wstate_next;
	logic [7:0] waddr_reg;
	logic [7:0] waddr_next;
	logic [7:0] wdata_reg;
	logic [7:0] wdata_next;
	logic wlane_reg;
	logic wlane_next;
	logic awready_reg;
	logic awready_next;
	logic wready_reg;
	logic wready_next;
	logic bvalid_reg;
	logic bvalid_next;
	logic [1:0] bresp_reg;
	logic [1:0] bresp_next;
	logic aw_fire;
	logic w_fire;
	logic commit;
	pifeb_sel_t wsel;

	always_comb
	begin
		aw_fire = s_axi_awvalid && awready_reg;
		w_fire = s_axi_wvalid && wready_reg;
		wstate_next = wstate_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wlane_next = wlane_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		commit = 1'b0;
		wsel = decode_addr(waddr_reg);
		if (aw_fire)
		begin
			waddr_next = s_axi_awaddr;
		end
		if (w_fire)
		begin
			wdata_next = s_axi_wdata[7:0];
			wlane_next = s_axi_wstrb[0];
		end
		case (wstate_reg)
			WS_IDLE:
			begin
				if (aw_fire && w_fire)
				begin
					wstate_next = WS_COMMIT;
				end
				else if (aw_fire)
				begin
					wstate_next = WS_GOT_ADDR;
				end
				else if (w_fire)
				begin
					wstate_next = WS_GOT_DATA;
				end
			end
			WS_GOT_ADDR:
			begin
				if (w_fire)
				begin
					wstate_next = WS_COMMIT;
				end
			end
			WS_GOT_DATA:
			begin
				if (aw_fire)
				begin
					wstate_next = WS_COMMIT;
				end
			end
			WS_COMMIT:
			begin
				commit = 1'b1;
				bvalid_next = 1'b1;
				bresp_next = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
				wstate_next = WS_RESP;
			end
			WS_RESP:
			begin
				if (s_axi_bready)
				begin
					bvalid_next = 1'b0;
					bresp_next = RESP_OKAY;
					wstate_next = WS_IDLE;
				end
			end
			default:
			begin
				wstate_next = WS_IDLE;
			end
		endcase
		awready_next = (wstate_next == WS_IDLE) || (wstate_next == WS_GOT_DATA);
		wready_next = (wstate_next == WS_IDLE) || (wstate_next == WS_GOT_ADDR);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wstate_reg <= WS_IDLE;
			waddr_reg <= RESET_BYTE;
			wdata_reg <= RESET_BYTE;
			wlane_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end
		else
		begin
			wstate_reg <= wstate_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wlane_reg <= wlane_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
		end
	end

	// Register bank
	logic byte_wr;
	logic [7:0] en1_reg;
	logic [7:0] en1_next;
	logic [7:0] en2_reg;
	logic [7:0] en2_next;
	logic [7:0] en3_reg;
	logic [7:0] en3_next;
	logic [7:0] ro_reg;
	logic [7:0] ro_next;
	logic [7:0] set3;
	logic [7:0] flags3;
	logic [7:0] sticky3;
	logic irq_reg;
	logic irq_next;
	logic [7:0] pend1;
	logic [7:0] pend2;
	logic [7:0] pend3;

	always_comb
	begin
		byte_wr = commit && wlane_reg;
		en1_next = en1_reg;
		en2_next = en2_reg;
		en3_next = en3_reg;
		if (byte_wr && (wsel == SEL_ENABLE1))
		begin
			en1_next = wdata_reg & impl1;
		end
		if (byte_wr && (wsel == SEL_ENABLE2))
		begin
			// Reserved bit is stored as written; software must keep it zero
			en2_next = wdata_reg & MASK_EN2_IMPL;
		end
		if (byte_wr && (wsel == SEL_ENABLE3))
		begin
			en3_next = wdata_reg & IMPL3;
		end
		// Events latch whatever the enables say, so polling works
		set3 = RESET_BYTE;
		set3[BIT_SP2_DONE] = serial_port2_done_evt;
		set3[BIT_SP2_COLL] = serial_port2_collision_evt;
		set3[BIT_TMR4] = timer_four_match_evt;
		set3[BIT_CC5] = capcomp_five_evt && !capcomp_pwm_mode[2];
		set3[BIT_CC4] = capcomp_four_evt && !capcomp_pwm_mode[1];
		set3[BIT_CC3] = capcomp_three_evt && !capcomp_pwm_mode[0];
		set3 = set3 & IMPL3_SW;
		// Read-only flags track the transceiver's buffer state
		ro_next = RESET_BYTE;
		ro_next[BIT_UART2_RX] = uart2_rx_full;
		ro_next[BIT_UART2_TX] = uart2_tx_empty;
		ro_next = ro_next & IMPL3;
	end

	genvar gi;
	generate
		for (gi = 0; gi < PIFEB_REG_W; gi = gi + 1)
		begin : g_flag3
			if (IMPL3_SW[gi])
			begin : g_sticky
				pifeb_sticky_flag u_flag
				(
					.aclk(aclk),
					.aresetn(aresetn),
					.set_evt(set3[gi]),
					.wr_en(byte_wr && (wsel == SEL_FLAGS3)),
					.wr_val(wdata_reg[gi]),
					.flag_q(sticky3[gi])
				);
			end
			else
			begin : g_none
				// Writes to read-only or absent positions are dropped
				assign sticky3[gi] = 1'b0;
			end
		end
	endgenerate

	always_comb
	begin
		flags3 = sticky3 | ro_reg;
		pend1 = periph_irq_flags_1 & en1_reg & impl1;
		pend2 = periph_irq_flags_2 & en2_reg & MASK_FL2_REQ;
		pend3 = flags3 & en3_reg;
		// Single-level mode needs the peripheral gate; two-level leaves it to priority logic
		irq_next = (|pend1 || |pend2 || |pend3)
			&& (priority_levels_enable || peripheral_irq_enable);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			en1_reg <= RESET_BYTE;
			en2_reg <= RESET_BYTE;
			en3_reg <= RESET_BYTE;
			ro_reg <= RESET_BYTE;
			irq_reg <= 1'b0;
		end
		else
		begin
			en1_reg <= en1_next;
			en2_reg <= en2_next;
			en3_reg <= en3_next;
			ro_reg <= ro_next;
			irq_reg <= irq_next;
		end
	end

	// Read channel; one cycle from address handshake to data
	logic arready_reg;
	logic arready_next;
	logic rvalid_reg;
	logic rvalid_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [1:0] rresp_reg;
	logic [1:0] rresp_next;
	logic [7:0] rbyte;
	pifeb_sel_t rsel;

	always_comb
	begin
		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		rsel = decode_addr(s_axi_araddr);
		case (rsel)
			SEL_FLAGS3: rbyte = flags3;
			SEL_ENABLE1: rbyte = en1_reg & impl1;
			SEL_ENABLE2: rbyte = en2_reg;
			SEL_ENABLE3: rbyte = en3_reg;
			default: rbyte = RESET_BYTE;
		endcase
		if (s_axi_arvalid && arready_reg)
		begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rdata_next = {24'h000000, rbyte};
			rresp_next = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end
		else if (rvalid_reg && s_axi_rready)
		begin
			arready_next = 1'b1;
			rvalid_next = 1'b0;
			rdata_next = ZERO_WORD;
			rresp_next = RESP_OKAY;
		end
		else if (!rvalid_reg)
		begin
			arready_next = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= ZERO_WORD;
			rresp_reg <= RESP_OKAY;
		end
		else
		begin
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign periph_irq_flags_3_q = flags3;
	assign periph_irq_enable_1_q = en1_reg;
	assign periph_irq_enable_2_q = en2_reg;
	assign periph_irq_enable_3_q = en3_reg;
	assign periph_irq_req = irq_reg;

endmodule : pifeb_bank

`default_nettype wire

// ===== tb/pifeb_bank_props.sv
`timescale 1ns/10ps
`default_nettype none

module pifeb_bank_props
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic serial_port2_done_evt,
	input wire logic serial_port2_collision_evt,
	input wire logic uart2_rx_full,
	input wire logic uart2_tx_empty,
	input wire logic timer_four_match_evt,
	input wire logic capcomp_five_evt,
	input wire logic capcomp_three_evt,
	input wire logic [2:0] capcomp_pwm_mode,
	input wire logic peripheral_irq_enable,
	input wire logic priority_levels_enable,
	input wire logic [7:0] periph_irq_flags_3_q,
	input wire logic [7:0] periph_irq_enable_3_q,
	input wire logic periph_irq_req
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_gate_off;
		(!priority_levels_enable && !peripheral_irq_enable) [*2];
	endsequence

	// Address channel ready (idle or data held): no register commit can land at the next edge
	sequence s_no_commit;
		s_axi_awready;
	endsequence

	a_done_sets: assert property (serial_port2_done_evt |=> periph_irq_flags_3_q[7])
		else $error("done event left its flag clear");
	a_coll_sets: assert property (serial_port2_collision_evt |=> periph_irq_flags_3_q[6])
		else $error("collision event left its flag clear");
	// Levels sampled during reset never reach the flags, so start one edge later
	a_uart_levels: assert property (aresetn |=>
		periph_irq_flags_3_q[5:4] == $past({uart2_rx_full, uart2_tx_empty}))
		else $error("buffer level flags do not follow the levels");
	a_tmr_sets: assert property (timer_four_match_evt |=> periph_irq_flags_3_q[3])
		else $error("timer match left its flag clear");
	a_cc5_sets: assert property (capcomp_five_evt
		&& !capcomp_pwm_mode[2] |=> periph_irq_flags_3_q[2])
		else $error("unit five event left its flag clear");
	a_cc3_pwm_block: assert property (s_no_commit ##0 (capcomp_three_evt
		&& capcomp_pwm_mode[0] && !periph_irq_flags_3_q[0]) |=> !periph_irq_flags_3_q[0])
		else $error("unit three flag set in pulse-width mode");
	a_sticky_hold: assert property (s_no_commit |=>
		(periph_irq_flags_3_q & $past(periph_irq_flags_3_q) & 8'hCF)
		== ($past(periph_irq_flags_3_q) & 8'hCF))
		else $error("sticky flag dropped without a write");
	a_req_gated: assert property (s_gate_off |=> !periph_irq_req)
		else $error("request raised while peripheral enable is off");
	a_req_cause: assert property (priority_levels_enable
		&& (|(periph_irq_flags_3_q & periph_irq_enable_3_q)) |=> periph_irq_req)
		else $error("enabled flag did not raise the request");
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before acceptance");
endmodule : pifeb_bank_props

bind pifeb_bank pifeb_bank_props pifeb_bank_props_i (.aclk, .aresetn, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bready, .serial_port2_done_evt, .serial_port2_collision_evt,
	.uart2_rx_full, .uart2_tx_empty, .timer_four_match_evt, .capcomp_five_evt,
	.capcomp_three_evt, .capcomp_pwm_mode, .peripheral_irq_enable, .priority_levels_enable,
	.periph_irq_flags_3_q, .periph_irq_enable_3_q, .periph_irq_req);

`default_nettype wire

// ===== tb/pifeb_periph_model.sv
`timescale 1ns/10ps
`default_nettype none

module pifeb_periph_model
(
	input wire logic aclk,
	output var logic [7:0] evt_q,
	output var logic [2:0] pwm_q
);
	initial
	begin
		evt_q = 8'h00;
		pwm_q = 3'h0;
	end

	// Events pulse for one cycle; buffer levels in bits 5 and 4 persist
	task automatic fire(input logic [7:0] m, input logic [2:0] p);
		@(posedge aclk);
		evt_q <= m;
		pwm_q <= p;
		@(posedge aclk);
		evt_q <= m & 8'h30;
	endtask : fire
endmodule : pifeb_periph_model

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top
	import pifeb_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic microcontroller_mode = 1'b1;
	logic peripheral_irq_enable = 1'b0;
	logic priority_levels_enable = 1'b0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [7:0] periph_irq_flags_1 = 8'h00;
	logic [7:0] periph_irq_flags_2 = 8'h00;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic periph_irq_req;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] evt;
	logic [2:0] pwm;
	logic [7:0] flags3_q, en1_q, en2_q, en3_q;
	int n_checks = 0;
	int n_mismatch = 0;

	pifeb_periph_model pifeb_periph_model_i (.aclk, .evt_q(evt), .pwm_q(pwm));

	pifeb_bank pifeb_bank_i
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_port2_done_evt(evt[7]),
		.serial_port2_collision_evt(evt[6]), .uart2_rx_full(evt[5]), .uart2_tx_empty(evt[4]),
		.timer_four_match_evt(evt[3]), .capcomp_five_evt(evt[2]), .capcomp_four_evt(evt[1]),
		.capcomp_three_evt(evt[0]), .capcomp_pwm_mode(pwm), .microcontroller_mode,
		.periph_irq_flags_1, .periph_irq_flags_2, .peripheral_irq_enable,
		.priority_levels_enable, .periph_irq_flags_3_q(flags3_q), .periph_irq_enable_1_q(en1_q),
		.periph_irq_enable_2_q(en2_q), .periph_irq_enable_3_q(en3_q), .periph_irq_req
	);

	initial
	forever #2 aclk = ~aclk;

	task automatic print_verdict();
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	task automatic rst();
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : rst

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (s_axi_awready !== 1'b1);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (s_axi_wready !== 1'b1);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, r)
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, {24'h000000, e})
		`CHK(s_axi_rresp, r)
		@(posedge aclk);
	endtask : rd

	task automatic t_regs();
		for (int a = 0; a < 16; a += 4)
			rd(8'(a), 8'h00, RESP_OKAY);
		rd(8'h10, 8'h00, RESP_SLVERR);
		wr(8'h10, 8'hFF, RESP_SLVERR);
		wr(OFS_ENABLE1, 8'hFF, RESP_OKAY);
		rd(OFS_ENABLE1, 8'hFF, RESP_OKAY);
		`CHK(en1_q, 8'hFF)
		microcontroller_mode <= 1'b0;
		rd(OFS_ENABLE1, 8'h7F, RESP_OKAY);
		wr(OFS_ENABLE2, 8'hEF, RESP_OKAY);
		rd(OFS_ENABLE2, 8'hEB, RESP_OKAY);
		`CHK(en2_q, 8'hEB)
		wr(OFS_ENABLE3, 8'hFF, RESP_OKAY);
		rd(OFS_ENABLE3, 8'hFF, RESP_OKAY);
		`CHK(en3_q, 8'hFF)
		wr(OFS_ENABLE3, 8'h00, RESP_OKAY);
		rd(OFS_ENABLE3, 8'h00, RESP_OKAY);
		// Lane 0 strobe low: acknowledged, but nothing lands
		s_axi_wstrb <= 4'h0;
		wr(OFS_ENABLE3, 8'hFF, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(OFS_ENABLE3, 8'h00, RESP_OKAY);
	endtask : t_regs

	task automatic t_flags();
		pifeb_periph_model_i.fire(8'hCF, 3'h0);
		rd(OFS_FLAGS3, 8'hCF, RESP_OKAY);
		`CHK(flags3_q, 8'hCF)
		pifeb_periph_model_i.fire(8'h30, 3'h0);
		rd(OFS_FLAGS3, 8'hFF, RESP_OKAY);
		wr(OFS_FLAGS3, 8'h00, RESP_OKAY);
		rd(OFS_FLAGS3, 8'h30, RESP_OKAY);
		pifeb_periph_model_i.fire(8'h07, 3'h7);
		rd(OFS_FLAGS3, 8'h00, RESP_OKAY);
	endtask : t_flags

	task automatic t_irq();
		wr(OFS_ENABLE3, 8'h08, RESP_OKAY);
		pifeb_periph_model_i.fire(8'h08, 3'h0);
		repeat (3) @(posedge aclk);
		`CHK(periph_irq_req, 1'b0)
		peripheral_irq_enable <= 1'b1;
		repeat (3) @(posedge aclk);
		`CHK(periph_irq_req, 1'b1)
		peripheral_irq_enable <= 1'b0;
		priority_levels_enable <= 1'b1;
		repeat (3) @(posedge aclk);
		`CHK(periph_irq_req, 1'b1)
		wr(OFS_ENABLE3, 8'h00, RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK(periph_irq_req, 1'b0)
		// Neighbouring banks; enable_1 still holds FF, enable_2 holds EB
		periph_irq_flags_1 <= 8'h80;
		repeat (3) @(posedge aclk);
		`CHK(periph_irq_req, 1'b0)
		periph_irq_flags_1 <= 8'h01;
		repeat (3) @(posedge aclk);
		`CHK(periph_irq_req, 1'b1)
		periph_irq_flags_1 <= 8'h00;
		periph_irq_flags_2 <= 8'h14;
		repeat (3) @(posedge aclk);
		`CHK(periph_irq_req, 1'b0)
		periph_irq_flags_2 <= 8'h08;
		repeat (3) @(posedge aclk);
		`CHK(periph_irq_req, 1'b1)
		periph_irq_flags_2 <= 8'h00;
		rst();
		rd(OFS_FLAGS3, 8'h00, RESP_OKAY);
		`CHK(en2_q, 8'h00)
	endtask : t_irq

	initial
	begin
		rst();
		t_regs();
		t_flags();
		t_irq();
		print_verdict();
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		print_verdict();
	end
endmodule : tb_top

`default_nettype wire
